// File: rtl/sfpc_pkg.sv
// Constants, timing counts, command words and operation codes for the
// sector flash program controller.
// Assumes a single 40 MHz clock; all pin timing is derived from it.
package sfpc_pkg;

	// Clock rate and printed pin timing
	localparam int CLK_MHZ = 40;
	localparam int AS_NS = 10;
	localparam int WP_NS = 200;
	localparam int WPH_NS = 200;
	localparam int OEHP_NS = 150;
	localparam int ACC_NS = 120;
	localparam int BLC_US = 150;
	localparam int WC_MS = 20;

	// Least times round up to whole cycles, never below one
	function automatic int sfpc_cyc_min(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : sfpc_cyc_min

	localparam int AS_CYC = sfpc_cyc_min(AS_NS);
	localparam int WP_CYC = sfpc_cyc_min(WP_NS);
	localparam int ACC_CYC = sfpc_cyc_min(ACC_NS);
	localparam int RECOV_CYC = (sfpc_cyc_min(WPH_NS) > sfpc_cyc_min(OEHP_NS)) ?
		sfpc_cyc_min(WPH_NS) : sfpc_cyc_min(OEHP_NS);
	// Longest times round down
	localparam int BLC_CYC = BLC_US * CLK_MHZ;
	localparam int WC_CYC = WC_MS * 1000 * CLK_MHZ;

	// Geometry
	localparam int SECTOR_BYTES = 128;
	localparam int ADDR_W = 17;
	localparam int SECT_W = 10;
	localparam logic [6:0] SECT_LAST = 7'h7f;
	localparam logic [16:0] ID_MFR_ADDR = 17'h00000;
	localparam logic [16:0] ID_DEV_ADDR = 17'h00001;

	// Command addresses (A14..A0) and data words
	localparam logic [14:0] CMD_ADDR_1 = 15'h5555;
	localparam logic [14:0] CMD_ADDR_2 = 15'h2aaa;
	localparam logic [7:0] CMD_UNLOCK_1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK_2 = 8'h55;
	localparam logic [7:0] CMD_PROG = 8'ha0;
	localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
	localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
	localparam logic [7:0] CMD_LOCK_PRE = 8'h80;
	localparam logic [7:0] CMD_LOCK_LO = 8'h40;
	localparam logic [7:0] CMD_LOCK_HI = 8'h60;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_PROG = 3'h1,
		OP_ID_READ = 3'h2,
		OP_ID_EXIT = 3'h3,
		OP_LOCK_LO = 3'h4,
		OP_LOCK_HI = 3'h5
	} sfpc_op_t;

	// Number of command writes that open an operation
	function automatic logic [2:0] sfpc_cmd_len(input sfpc_op_t op);
		case (op)
			OP_PROG, OP_ID_READ, OP_ID_EXIT: return 3'h3;
			OP_LOCK_LO, OP_LOCK_HI: return 3'h6;
			default: return 3'h0;
		endcase
	endfunction : sfpc_cmd_len

	// Command word {address, data} for step idx of an operation
	function automatic logic [22:0] sfpc_cmd_word(input sfpc_op_t op, input logic [2:0] idx);
		logic [7:0] third;
		third = CMD_PROG;
		case (op)
			OP_ID_READ: third = CMD_ID_ENTRY;
			OP_ID_EXIT: third = CMD_ID_EXIT;
			OP_LOCK_LO, OP_LOCK_HI: third = CMD_LOCK_PRE;
			default: third = CMD_PROG;
		endcase
		case (idx)
			3'h0, 3'h3: return {CMD_ADDR_1, CMD_UNLOCK_1};
			3'h1, 3'h4: return {CMD_ADDR_2, CMD_UNLOCK_2};
			3'h2: return {CMD_ADDR_1, third};
			default: return {CMD_ADDR_1, (op == OP_LOCK_HI) ? CMD_LOCK_HI : CMD_LOCK_LO};
		endcase
	endfunction : sfpc_cmd_word

endpackage : sfpc_pkg

// File: rtl/sfpc_bus_cycle.sv
// One read or write strobe cycle on the flash pins.
// Assumes the caller holds off i_req until o_done of the previous cycle.
`timescale 1ns/1ps
module sfpc_bus_cycle
	import sfpc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_write,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_dq_i,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic [ADDR_W-1:0] o_addr,
	output logic [7:0] o_dq_o,
	output logic o_dq_oe,
	output logic [7:0] o_rdata,
	output logic o_done
);

	typedef enum logic [3:0] {
		BC_IDLE = 4'b0001,
		BC_SETUP = 4'b0010,
		BC_STROBE = 4'b0100,
		BC_RECOV = 4'b1000
	} sfpc_bc_t;

	sfpc_bc_t state_q;
	logic [3:0] cnt_q;
	logic write_q;
	wire cnt_zero = (cnt_q == 4'h0);
	wire [3:0] strobe_len = write_q ? 4'(WP_CYC - 1) : 4'(ACC_CYC - 1);

	// Strobe sequencer; OE stays high for the whole of a write
	always_ff @(posedge i_clk)
	begin
		o_done <= 1'b0;
		if (i_rst)
		begin
			state_q <= BC_IDLE;
			cnt_q <= 4'h0;
			write_q <= 1'b0;
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_addr <= '0;
			o_dq_o <= 8'h00;
			o_dq_oe <= 1'b0;
			o_rdata <= 8'h00;
		end
		else
		begin
			cnt_q <= cnt_zero ? 4'h0 : cnt_q - 4'h1;
			case (state_q)
				BC_IDLE:
					if (i_req)
					begin
						// Address, data and CE settle before the strobe falls
						write_q <= i_write;
						o_addr <= i_addr;
						o_dq_o <= i_wdata;
						o_dq_oe <= i_write;
						o_ce_n <= 1'b0;
						cnt_q <= 4'(AS_CYC - 1);
						state_q <= BC_SETUP;
					end
				BC_SETUP:
					if (cnt_zero)
					begin
						o_we_n <= ~write_q;
						o_oe_n <= write_q; // RULE_01
						cnt_q <= strobe_len;
						state_q <= BC_STROBE;
					end
				BC_STROBE:
					if (cnt_zero)
					begin
						if (!write_q)
							o_rdata <= i_dq_i;
						// Each read ends with OE high, so the toggle line advances
						o_we_n <= 1'b1;
						o_oe_n <= 1'b1; // RULE_07
						o_ce_n <= 1'b1;
						cnt_q <= 4'(RECOV_CYC - 1);
						state_q <= BC_RECOV;
					end
				BC_RECOV:
					if (cnt_zero)
					begin
						// Data held through recovery covers the hold time
						o_dq_oe <= 1'b0;
						o_done <= 1'b1;
						state_q <= BC_IDLE;
					end
				default:
					state_q <= BC_IDLE;
			endcase
		end
	end

endmodule : sfpc_bus_cycle

// File: rtl/sfpc_host.sv
// Host controller for a parallel sector flash: command sequences,
// 128-byte sector loads, toggle/poll completion, ID and boot lockout.
// Assumes the flash pins are wired directly and sampled on i_clk.
`timescale 1ns/1ps
// Operation
// [RULE_01] Keep OE high during byte-load strobes
// [RULE_02] Sector address on A16..A7 every load
// [RULE_03] Unloaded sector bytes end up undefined
// [RULE_04] Protection re-arms after each program cycle
// [RULE_05] Always load all 128 sector bytes
// [RULE_06] Next load within 150 us window
// [RULE_07] Toggle line flips on each read strobe
// [RULE_08] Toggle start and end states are meaningless
// [RULE_09] Poll reads hold one fixed address
// [RULE_10] ID mode: A0 picks maker or device code
// [RULE_11] ID mode lost on power down
// [RULE_12] ID exit sequence restores array reads
// [RULE_13] Boot lockout locks lower or upper block
// [RULE_14] Commands use I/O7..0 data, A14..A0 address
// [RULE_15] Reads during program cycle return status
// [RULE_16] Poll line shows complemented bit 7 while busy
module sfpc_host
	import sfpc_pkg::*;
#(
	parameter int BLC_CYCLES = BLC_CYC,
	parameter int WC_CYCLES = WC_CYC
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic [2:0] i_op,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [SECT_W-1:0] i_sector,
	input wire logic i_wr_valid,
	input wire logic [7:0] i_wr_data,
	output logic o_wr_ready,
	output logic o_busy,
	output logic o_done,
	output logic o_err,
	output logic [7:0] o_rdata,
	output logic [15:0] o_id_code,
	output logic o_id_mode,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic [ADDR_W-1:0] o_addr,
	output logic [7:0] o_dq_o,
	output logic o_dq_oe,
	input wire logic [7:0] i_dq_i
);

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_CMD = 7'b0000010,
		ST_LOAD = 7'b0000100,
		ST_POLL = 7'b0001000,
		ST_READ = 7'b0010000,
		ST_IDRD = 7'b0100000,
		ST_FIN = 7'b1000000
	} sfpc_st_t;

	// Gap budget: window runs from one WE fall to the next
	localparam int GAP_CYC = BLC_CYCLES - WP_CYC - RECOV_CYC - AS_CYC - 2;
	localparam int BLC_W = $clog2(BLC_CYCLES + 1);
	localparam int WC_W = $clog2(WC_CYCLES + 1);

	sfpc_st_t state_q;
	sfpc_op_t op_q;
	logic [ADDR_W-1:0] raddr_q;
	logic [SECT_W-1:0] sector_q;
	logic [7:0] idx_q;
	logic req_q;
	logic wait_q;
	logic last_bit7_q;
	logic tog_prev_q;
	logic tog_have_q;
	logic [BLC_W-1:0] blc_cnt_q;
	logic [WC_W-1:0] wc_cnt_q;
	logic [ADDR_W-1:0] baddr_q;
	logic [7:0] bdata_q;
	logic bwrite_q;
	logic bus_done;
	logic [7:0] bus_rdata;

	// Request decode and bus word selection
	wire accept = (state_q == ST_LOAD) && o_wr_ready && i_wr_valid;
	wire issue_auto = !wait_q && !req_q &&
		(state_q == ST_CMD || state_q == ST_POLL || state_q == ST_READ || state_q == ST_IDRD);
	wire issue = issue_auto || accept;
	wire [22:0] cmd_word = sfpc_cmd_word(op_q, idx_q[2:0]);
	wire [2:0] cmd_len = sfpc_cmd_len(op_q);
	wire cmd_last = (idx_q[2:0] == cmd_len - 3'h1);
	wire [ADDR_W-1:0] cmd_addr = {2'b00, cmd_word[22:8]}; // RULE_14
	wire [ADDR_W-1:0] load_addr = {sector_q, idx_q[6:0]}; // RULE_02
	// Fixed poll address: last byte of the sector, or the command address
	wire [ADDR_W-1:0] poll_addr = (op_q == OP_PROG) ? {sector_q, SECT_LAST} : cmd_addr; // RULE_09
	wire [ADDR_W-1:0] id_addr = idx_q[0] ? ID_DEV_ADDR : ID_MFR_ADDR; // RULE_10
	wire [ADDR_W-1:0] issue_addr = (state_q == ST_CMD) ? cmd_addr :
		(state_q == ST_LOAD) ? load_addr :
		(state_q == ST_POLL) ? poll_addr :
		(state_q == ST_IDRD) ? id_addr : raddr_q;
	wire [7:0] issue_data = (state_q == ST_LOAD) ? i_wr_data : cmd_word[7:0];
	wire issue_write = (state_q == ST_CMD) || (state_q == ST_LOAD);
	wire load_last = (idx_q == 8'(SECTOR_BYTES - 1));
	wire gap_over = (blc_cnt_q >= BLC_W'(GAP_CYC));
	wire wc_over = (wc_cnt_q >= WC_W'(WC_CYCLES));
	// Done when toggle stops between two reads and, for a program, bit 7 is true data
	wire tog_still = tog_have_q && (tog_prev_q == bus_rdata[6]); // RULE_08
	wire poll_match = (op_q != OP_PROG) || (bus_rdata[7] == last_bit7_q); // RULE_16
	wire start_ok = (sfpc_cmd_len(sfpc_op_t'(i_op)) != 3'h0) || (i_op == OP_READ);

	// Bus request latch; one cycle in flight at a time
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			req_q <= 1'b0;
			wait_q <= 1'b0;
			baddr_q <= '0;
			bdata_q <= 8'h00;
			bwrite_q <= 1'b0;
		end
		else
		begin
			req_q <= issue;
			if (issue)
			begin
				wait_q <= 1'b1;
				baddr_q <= issue_addr;
				bdata_q <= issue_data;
				bwrite_q <= issue_write;
			end
			else if (bus_done)
				wait_q <= 1'b0;
		end
	end

	// Window and cycle timers; a stalled data source costs the sector
	always_ff @(posedge i_clk)
	begin
		if (i_rst || state_q != ST_LOAD || !o_wr_ready)
			blc_cnt_q <= '0;
		else if (!gap_over)
			blc_cnt_q <= blc_cnt_q + BLC_W'(1); // RULE_06
		if (i_rst || state_q != ST_POLL)
			wc_cnt_q <= '0;
		else if (!wc_over)
			wc_cnt_q <= wc_cnt_q + WC_W'(1);
	end

	// Operation sequencer
	always_ff @(posedge i_clk)
	begin
		o_done <= 1'b0;
		if (i_rst)
		begin
			state_q <= ST_IDLE;
			op_q <= OP_READ;
			raddr_q <= '0;
			sector_q <= '0;
			idx_q <= 8'h00;
			o_wr_ready <= 1'b0;
			o_busy <= 1'b0;
			o_err <= 1'b0;
			o_rdata <= 8'h00;
			o_id_code <= 16'h0000;
			o_id_mode <= 1'b0;
			last_bit7_q <= 1'b0;
			tog_prev_q <= 1'b0;
			tog_have_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
					if (i_start)
					begin
						op_q <= sfpc_op_t'(i_op);
						raddr_q <= i_addr;
						sector_q <= i_sector;
						idx_q <= 8'h00;
						o_busy <= 1'b1;
						o_err <= !start_ok;
						// Every program opens with the full unlock sequence
						state_q <= !start_ok ? ST_FIN :
							(i_op == OP_READ) ? ST_READ : ST_CMD; // RULE_04
					end
				ST_CMD:
					if (bus_done)
					begin
						idx_q <= cmd_last ? 8'h00 : idx_q + 8'h01;
						tog_have_q <= 1'b0;
						if (cmd_last)
						begin
							o_wr_ready <= (op_q == OP_PROG);
							o_id_mode <= (op_q == OP_ID_READ);
							// Lockout variants start an internal write; poll it out
							case (op_q)
								OP_PROG: state_q <= ST_LOAD;
								OP_ID_READ: state_q <= ST_IDRD;
								OP_LOCK_LO, OP_LOCK_HI: state_q <= ST_POLL; // RULE_13
								default: state_q <= ST_FIN; // RULE_12
							endcase
						end
					end
				ST_LOAD:
				begin
					if (accept)
					begin
						o_wr_ready <= 1'b0;
						last_bit7_q <= i_wr_data[7];
					end
					else if (o_wr_ready && gap_over)
					begin
						// Window missed: device programs a partial sector
						o_wr_ready <= 1'b0;
						o_err <= 1'b1; // RULE_03
						state_q <= ST_POLL;
					end
					if (bus_done)
					begin
						idx_q <= idx_q + 8'h01;
						if (load_last)
							state_q <= ST_POLL; // RULE_05
						else
							o_wr_ready <= 1'b1;
					end
				end
				ST_POLL:
					if (bus_done)
					begin
						// Reads here return status while the cycle runs, then array data once it ends
						tog_prev_q <= bus_rdata[6]; // RULE_15
						tog_have_q <= 1'b1;
						if (tog_still && poll_match)
							state_q <= ST_FIN;
						else if (wc_over)
						begin
							o_err <= 1'b1;
							state_q <= ST_FIN;
						end
					end
				ST_READ:
					if (bus_done)
					begin
						o_rdata <= bus_rdata;
						state_q <= ST_FIN;
					end
				ST_IDRD:
					if (bus_done)
					begin
						idx_q <= idx_q + 8'h01;
						if (idx_q[0])
						begin
							o_id_code[7:0] <= bus_rdata;
							state_q <= ST_FIN;
						end
						else
							o_id_code[15:8] <= bus_rdata;
					end
				ST_FIN:
				begin
					// ID exit clears the mode flag; power loss is outside our view
					if (op_q == OP_ID_EXIT)
						o_id_mode <= 1'b0; // RULE_12
					o_busy <= 1'b0;
					o_done <= 1'b1;
					state_q <= ST_IDLE;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Pin-level strobe engine
	sfpc_bus_cycle u_bus (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_req(req_q),
		.i_write(bwrite_q),
		.i_addr(baddr_q),
		.i_wdata(bdata_q),
		.i_dq_i(i_dq_i),
		.o_ce_n(o_ce_n),
		.o_oe_n(o_oe_n),
		.o_we_n(o_we_n),
		.o_addr(o_addr),
		.o_dq_o(o_dq_o),
		.o_dq_oe(o_dq_oe),
		.o_rdata(bus_rdata),
		.o_done(bus_done)
	);

endmodule : sfpc_host

// File: tb/sfpc_props.sv
// Pin and op-port checker for the sector flash host.
// Assumes it is bound to sfpc_host and sees only its ports.
`timescale 1ns/1ps
module sfpc_props
	import sfpc_pkg::*;
#(
	parameter int BLC_CYCLES = BLC_CYC
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic [2:0] i_op,
	input wire logic [SECT_W-1:0] i_sector,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_err,
	input wire logic o_id_mode,
	input wire logic o_ce_n,
	input wire logic o_oe_n,
	input wire logic o_we_n,
	input wire logic [ADDR_W-1:0] o_addr,
	input wire logic [7:0] o_dq_o,
	input wire logic o_dq_oe
);
	logic [2:0] op_q;
	logic [SECT_W-1:0] sec_q;
	logic [7:0] n_q;
	logic we_q;
	int gap_q;
	wire wf = we_q && !o_we_n;
	wire prog = op_q == 3'h1;
	// Op, sector and write count since start; gap between WE falls
	always_ff @(posedge i_clk)
	begin
		we_q <= o_we_n;
		gap_q <= wf ? 0 : gap_q + 1;
		if (i_rst)
			op_q <= 3'h0;
		if (i_rst || (i_start && !o_busy))
			n_q <= 8'h00;
		else if (wf)
			n_q <= n_q + 8'h01;
		if (i_start && !o_busy && !i_rst)
		begin
			op_q <= i_op;
			sec_q <= i_sector;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_oe_during_we: assert property (!(!o_we_n && !o_ce_n && !o_oe_n))
		else $error("OE low during a write strobe");
	a_no_contend: assert property (!o_oe_n |-> !o_dq_oe)
		else $error("host drives DQ while OE low");
	a_sector_addr: assert property (prog && wf && n_q >= 8'h03 |-> o_addr[16:7] == sec_q)
		else $error("load outside target sector");
	a_cmd_first: assert property ($rose(o_we_n) && n_q == 8'h01
		&& op_q inside {[3'h1:3'h5]} |-> o_addr[14:0] == 15'h5555 && o_dq_o == 8'haa && o_dq_oe)
		else $error("bad first command write");
	a_prog_code: assert property (prog && $rose(o_we_n) && n_q == 8'h03 |-> o_dq_o == 8'ha0)
		else $error("program code missing");
	a_lock_code: assert property ($rose(o_we_n) && n_q == 8'h06 && op_q[2:1] == 2'h2
		|-> o_dq_o == (op_q[0] ? 8'h60 : 8'h40))
		else $error("wrong lockout code");
	a_load_count: assert property (o_done && prog && !o_err |-> n_q == 8'h83)
		else $error("sector load not 128 bytes");
	a_load_gap: assert property (prog && wf && n_q >= 8'h03 |-> gap_q < BLC_CYCLES)
		else $error("byte load window exceeded");
	a_poll_addr: assert property (prog && n_q == 8'h83 && $fell(o_oe_n)
		|-> o_addr == {sec_q, 7'h7f})
		else $error("poll address moved");
	a_id_addr: assert property (op_q == 3'h2 && $fell(o_oe_n) |-> o_addr[16:1] == 16'h0000)
		else $error("code read with high address bits");
	a_id_exit: assert property (o_done && op_q == 3'h3 |-> !o_id_mode)
		else $error("code mode kept after exit");
	a_read_time: assert property (i_start && !o_busy && i_op == 3'h0 |-> ##[1:30] o_done)
		else $error("read did not finish");
endmodule : sfpc_props

bind sfpc_host sfpc_props #(.BLC_CYCLES(BLC_CYCLES)) u_props (.i_clk(i_clk), .i_rst(i_rst),
	.i_start(i_start), .i_op(i_op), .i_sector(i_sector), .o_busy(o_busy), .o_done(o_done),
	.o_err(o_err), .o_id_mode(o_id_mode), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
	.o_addr(o_addr), .o_dq_o(o_dq_o), .o_dq_oe(o_dq_oe));

// File: tb/sfpc_flash_model.sv
// Behavioural parallel sector flash for the host bench.
// Assumes the bench resolves DQ: host data while it drives, else o_dq.
`timescale 1ns/1ps
module sfpc_flash_model #(
	parameter logic [7:0] MFR = 8'hc3, // Arbitrary value
	parameter logic [7:0] DEV = 8'h9e, // Arbitrary value
	parameter realtime BLC_NS = 5000.0,
	parameter realtime BUSY_NS = 20000.0
)
(
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic [16:0] i_addr,
	input wire logic [7:0] i_dq,
	output logic [7:0] o_dq,
	output logic [1:0] o_lock,
	output int o_loads
);
	logic [7:0] mem [128];
	logic [7:0] last = 8'h00, dq_q = 8'h00;
	logic [22:0] k;
	logic [2:0] seq = 3'h0;
	logic arm = 1'b0, id = 1'b0, tog = 1'b1;
	realtime t_load = 0.0, t_end = 0.0;
	wire wr = !i_we_n && !i_ce_n;
	wire rd = !i_oe_n && !i_ce_n;
	// Array starts with a known pattern
	initial
	begin
		o_lock = 2'h0;
		o_loads = 0;
		foreach (mem[i])
			mem[i] = 8'(i) ^ 8'h5a;
	end
	// Lapsed load window starts the cycle, checked lazily at each strobe
	task automatic expire;
		if (arm && $realtime - t_load > BLC_NS)
		begin
			arm = 1'b0;
			t_end = $realtime + BUSY_NS;
		end
	endtask : expire
	// Loads and command decode at the end of each write strobe
	always @(negedge wr)
	begin
		expire();
		k = {i_addr[14:0], i_dq};
		if ($realtime < t_end)
			seq = 3'h0;
		else if (arm)
		begin
			mem[i_addr[6:0]] = i_dq;
			last = i_dq;
			o_loads++;
			t_load = $realtime;
			if (o_loads == 128)
			begin
				arm = 1'b0;
				t_end = $realtime + BUSY_NS;
			end
		end
		else if (seq == 3'h0 || seq == 3'h3)
			seq = (k === {15'h5555, 8'haa}) ? seq + 3'h1 : 3'h0;
		else if (seq == 3'h1 || seq == 3'h4)
			seq = (k === {15'h2aaa, 8'h55}) ? seq + 3'h1 : 3'h0;
		else if (seq == 3'h2)
		begin
			seq = (k === {15'h5555, 8'h80}) ? 3'h3 : 3'h0;
			id = (k === {15'h5555, 8'h90}) || (id && k !== {15'h5555, 8'hf0});
			if (k === {15'h5555, 8'ha0})
			begin
				arm = 1'b1;
				o_loads = 0;
				t_load = $realtime;
				foreach (mem[i])
					mem[i] = ~mem[i];
			end
		end
		else
		begin
			seq = 3'h0;
			o_lock = o_lock | {k === {15'h5555, 8'h60}, k === {15'h5555, 8'h40}};
			t_end = $realtime + BUSY_NS;
		end
	end
	// Status replaces array data while the cycle runs
	always @(posedge rd)
	begin
		expire();
		if ($realtime < t_end)
		begin
			tog = ~tog;
			dq_q = {~last[7], tog, 6'h2a};
		end
		else if (id && i_addr[16:1] == 16'h0000)
			dq_q = i_addr[0] ? DEV : MFR;
		else
			dq_q = mem[i_addr[6:0]];
	end
	// Released bus shows the inverse, so a stale sample cannot pass
	assign o_dq = rd ? dq_q : ~dq_q;
endmodule : sfpc_flash_model

// File: tb/sfpc_host_tb.sv
// Self-checking bench for sfpc_host against a behavioural flash.
// Assumes shortened window and cycle counts set at the instance.
`timescale 1ns/1ps
module sfpc_host_tb;
	logic i_clk, i_rst, i_start, i_wr_valid, o_wr_ready, o_busy, o_done, o_err, o_id_mode;
	logic o_ce_n, o_oe_n, o_we_n, o_dq_oe;
	logic [2:0] i_op;
	logic [16:0] i_addr, o_addr;
	logic [9:0] i_sector;
	logic [7:0] i_wr_data, o_rdata, o_dq_o, f_dq;
	logic [15:0] o_id_code;
	logic [1:0] f_lock;
	logic [6:0] idx;
	logic [7:0] dat [128];
	int f_loads, errors = 0, checks_done = 0;
	wire [7:0] dq = o_dq_oe ? o_dq_o : f_dq;
	sfpc_host #(.BLC_CYCLES(200), .WC_CYCLES(2000)) uut (.i_clk(i_clk), .i_rst(i_rst),
		.i_start(i_start), .i_op(i_op), .i_addr(i_addr), .i_sector(i_sector),
		.i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready),
		.o_busy(o_busy), .o_done(o_done), .o_err(o_err), .o_rdata(o_rdata),
		.o_id_code(o_id_code), .o_id_mode(o_id_mode), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
		.o_we_n(o_we_n), .o_addr(o_addr), .o_dq_o(o_dq_o), .o_dq_oe(o_dq_oe), .i_dq_i(dq));
	sfpc_flash_model u_flash (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
		.i_addr(o_addr), .i_dq(dq), .o_dq(f_dq), .o_lock(f_lock), .o_loads(f_loads));
	// Clock and byte stream; next byte once the current one is taken
	initial
	begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
		if (i_wr_valid && o_wr_ready)
			idx <= #2 idx + 7'h01;
	assign i_wr_data = dat[idx];
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// One op, start to done pulse, bounded wait
	task automatic run(input logic [2:0] op, input logic [16:0] a, input logic [9:0] s);
		int n;
		n = 0;
		i_start = 1'b1;
		i_op = op;
		i_addr = a;
		i_sector = s;
		@(posedge i_clk);
		#2 i_start = 1'b0;
		chk("busy", o_busy, 1);
		do
		begin
			@(posedge i_clk);
			#2 n++;
		end
		while (o_done !== 1'b1 && n < 20000);
		chk("done", o_done, 1);
		chk("idle", o_busy, 0);
	endtask : run
	task automatic t_id_lock;
		run(3'h0, 17'h00a05, 10'h000);
		chk("rd", o_rdata, 8'h05 ^ 8'h5a);
		run(3'h2, 17'h00000, 10'h000);
		chk("id_code", o_id_code, 16'hc39e);
		chk("id_mode", o_id_mode, 1);
		run(3'h3, 17'h00000, 10'h000);
		chk("id_off", o_id_mode, 0);
		run(3'h0, 17'h00001, 10'h000);
		chk("id_rd", o_rdata, 8'h01 ^ 8'h5a);
		run(3'h4, 17'h00000, 10'h000);
		chk("lock_lo", f_lock, 2'h1);
		run(3'h5, 17'h00000, 10'h000);
		chk("lock_hi", f_lock, 2'h3);
		run(3'h7, 17'h00000, 10'h000);
		chk("bad_op", o_err, 1);
		$display("t_id_lock end");
	endtask : t_id_lock
	// Full sector load, poll, then read back both ends of the sector
	task automatic t_prog(input logic [9:0] s, input logic [7:0] m);
		for (int i = 0; i < 128; i++)
			dat[i] = 8'(i) * m + 8'h01;
		idx = 7'h00;
		i_wr_valid = 1'b1;
		run(3'h1, 17'h00000, s);
		i_wr_valid = 1'b0;
		chk("prog_err", o_err, 0);
		chk("loads", f_loads, 128);
		run(3'h0, {s, 7'h00}, 10'h000);
		chk("byte0", o_rdata, dat[0]);
		run(3'h0, {s, 7'h7f}, 10'h000);
		chk("byte127", o_rdata, dat[127]);
		$display("t_prog end");
	endtask : t_prog
	// No bytes offered: window lapses and the op ends in error
	task automatic t_stall;
		i_wr_valid = 1'b0;
		run(3'h1, 17'h00000, 10'h003);
		chk("stall_err", o_err, 1);
		chk("stall_rdy", o_wr_ready, 0);
		chk("stall_loads", f_loads, 0);
		$display("t_stall end");
	endtask : t_stall
	initial
	begin
		i_rst = 1'b1;
		i_start = 1'b0;
		i_op = 3'h0;
		i_addr = 17'h00000;
		i_sector = 10'h000;
		i_wr_valid = 1'b0;
		idx = 7'h00;
		repeat (2) @(posedge i_clk);
		#2 i_rst = 1'b0;
		t_id_lock();
		t_prog(10'h155, 8'h03);
		t_prog(10'h2aa, 8'h05);
		t_stall();
		test_done();
	end
	// Watchdog well beyond the expected run of about 10000 cycles
	initial
	begin
		#2000000;
		errors++;
		test_done();
	end
endmodule : sfpc_host_tb
